// [hdl/hpm_pkg.sv]
// Purpose: constants for the hub pin-role swap and logical port remap block
// Assumes: 8-bit register port, byte offsets as printed
// Notes:   third map register and remap enable register are local offsets
package hpm_pkg;
   localparam logic [7:0] HPM_ADDR_SWAP    = 8'hfa;  // pin role swap mask
   localparam logic [7:0] HPM_ADDR_MAP12   = 8'hfb;  // ports one and two map
   localparam logic [7:0] HPM_ADDR_MAP3    = 8'hfc;  // port three map
   localparam logic [7:0] HPM_ADDR_CTRL    = 8'hf0;  // remap enable, bit 0
   localparam logic [7:0] HPM_ADDR_STAT    = 8'hf1;  // port count, read only
   localparam logic [7:0] HPM_SWAP_RST     = 8'h00;
   localparam logic [7:0] HPM_MAP12_RST    = 8'h21;  // identity mapping
   localparam logic [7:0] HPM_MAP3_RST     = 8'h03;
   localparam logic [7:0] HPM_CTRL_RST     = 8'h00;
   localparam logic [3:0] HPM_SWAP_USED    = 4'hf;   // low nibble live, upper reserved
   localparam logic [3:0] HPM_CODE_OFF     = 4'h0;   // port disabled
   localparam logic [3:0] HPM_CODE_MAX     = 4'h3;   // highest legal logical number
   localparam int         HPM_NUM_DS       = 3;      // downstream ports
   localparam int         HPM_NUM_PORTS    = 4;      // upstream plus downstream
   localparam int         HPM_CTRL_EN_BIT  = 0;
endpackage : hpm_pkg

// [hdl/hpm_port_remap.sv]
// Purpose: hub pin-role swap muxes and physical-to-logical port remap
// Assumes: register port in SYS_CLK domain; pins sampled through two flops
// Notes:   all outputs registered; core-to-pin paths carry one cycle of latency, pin-to-core three
//          map rewrites are not atomic; hold the ports idle meanwhile
//          reserved bits are stored and read back but drive nothing
//
// Strobed register access is this design's own decision.
module hpm_port_remap
   import hpm_pkg::*;
(
   input  wire logic       SYS_CLK,
   input  wire logic       RST,
   input  wire logic [7:0] ADDR,
   input  wire logic [7:0] WDATA,
   input  wire logic       WR,
   input  wire logic       RD,
   output logic      [7:0] RDATA,
   input  wire logic [3:0] CORE_DP_OUT,
   input  wire logic [3:0] CORE_DM_OUT,
   input  wire logic [3:0] CORE_DRV_EN,
   input  wire logic [3:0] PIN_DP_IN,
   input  wire logic [3:0] PIN_DM_IN,
   output logic      [3:0] PIN_DP_OUT,
   output logic      [3:0] PIN_DM_OUT,
   output logic      [3:0] PIN_DP_OE,
   output logic      [3:0] PIN_DM_OE,
   output logic      [3:0] CORE_DP_IN,
   output logic      [3:0] CORE_DM_IN,
   input  wire logic [1:0] REQ_LOGICAL,
   output logic      [2:0] REQ_PHYS_SEL,
   output logic      [1:0] PORT_COUNT,
   output logic      [5:0] PORT_LOGICAL
);

   // configuration registers and read data
   logic [7:0] swap_ff;
   logic [7:0] map12_ff;
   logic [7:0] map3_ff;
   logic [7:0] ctrl_ff;
   logic [7:0] rdata_ff;

   // pin pipeline: two synchroniser stages, then the registered role mux
   logic [3:0] dp_meta_ff;
   logic [3:0] dm_meta_ff;
   logic [3:0] dp_sync_ff;
   logic [3:0] dm_sync_ff;
   logic [3:0] dp_out_ff;
   logic [3:0] dm_out_ff;
   logic [3:0] dp_oe_ff;
   logic [3:0] dm_oe_ff;
   logic [3:0] dp_in_ff;
   logic [3:0] dm_in_ff;

   // remap pipeline: effective codes, decoded numbers, registered results
   logic [2:0] sel_ff;
   logic [1:0] count_ff;
   logic [5:0] logical_ff;
   logic [3:0] code [HPM_NUM_DS];
   logic       code_live [HPM_NUM_DS];   // enabled with a legal number
   logic [1:0] code_num  [HPM_NUM_DS];   // logical number, zero when off
   logic [2:0] nxt_sel;
   logic [1:0] nxt_count;
   logic       remap_enable;

   // register map, every stored byte reads back what was written:
   //    swap mask      bit 0 upstream, bits 1..3 downstream, 7..4 kept only
   //    map ports 1,2  low nibble physical one, high nibble physical two
   //    map port 3     low nibble physical three, high nibble kept only
   //    control        bit 0 is remap enable, other bits kept only
   //    status         read only, number of enabled downstream ports
   // any other address reads zero and ignores writes
   // the bank only moves numbers; the hub core must keep the ports idle
   // while software rewrites a map, since a half-written pair of nibbles
   // can briefly show a gap or a duplicate to the routing logic
   assign remap_enable = ctrl_ff[HPM_CTRL_EN_BIT];

   // configuration writes; reserved swap bits are stored but feed nothing
   // writes to status or to unmapped addresses fall through every branch,
   // so the count can only ever come from the map and control registers
   always_ff @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
      begin
         swap_ff  <= HPM_SWAP_RST;
         map12_ff <= HPM_MAP12_RST;
         map3_ff  <= HPM_MAP3_RST;
         ctrl_ff  <= HPM_CTRL_RST;
      end
      else if (WR)
      begin
         if (ADDR == HPM_ADDR_SWAP)
         begin
            swap_ff <= WDATA;
         end
         else if (ADDR == HPM_ADDR_MAP12)
         begin
            map12_ff <= WDATA;
         end
         else if (ADDR == HPM_ADDR_MAP3)
         begin
            map3_ff <= WDATA;
         end
         else if (ADDR == HPM_ADDR_CTRL)
         begin
            ctrl_ff <= WDATA;
         end
      end
   end

   // read data stands in the cycle after the strobe only; unmapped reads zero
   // clearing between reads keeps an idle bus at zero, so a master that
   // samples one cycle late sees a plain zero rather than stale data
   always_ff @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
      begin
         rdata_ff <= 8'h00;
      end
      else if (!RD)
      begin
         rdata_ff <= 8'h00;
      end
      else if (ADDR == HPM_ADDR_SWAP)
      begin
         rdata_ff <= swap_ff;
      end
      else if (ADDR == HPM_ADDR_MAP12)
      begin
         rdata_ff <= map12_ff;
      end
      else if (ADDR == HPM_ADDR_MAP3)
      begin
         rdata_ff <= map3_ff;
      end
      else if (ADDR == HPM_ADDR_CTRL)
      begin
         rdata_ff <= ctrl_ff;
      end
      else if (ADDR == HPM_ADDR_STAT)
      begin
         rdata_ff <= {6'h00, count_ff};
      end
      else
      begin
         rdata_ff <= 8'h00;
      end
   end

   // pin inputs come from the bus wire, so two flops before any use
   // limitation: with the role mux behind them a pin level reaches the
   // core three cycles later; the core must allow for that in its line
   // state decoding, traded for freedom from metastable samples
   always_ff @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
      begin
         dp_meta_ff <= 4'h0;
         dm_meta_ff <= 4'h0;
         dp_sync_ff <= 4'h0;
         dm_sync_ff <= 4'h0;
      end
      else
      begin
         dp_meta_ff <= PIN_DP_IN;
         dm_meta_ff <= PIN_DM_IN;
         dp_sync_ff <= dp_meta_ff;
         dm_sync_ff <= dm_meta_ff;
      end
   end

   // per-port role muxes; bit 0 upstream, bits 1..3 downstream
   // both enables follow the one core enable: a swapped pair still drives
   // or floats as a pair, so only the meaning of the two pins changes
   for (genvar p = 0; p < HPM_NUM_PORTS; p++)
   begin : g_swap
      always_ff @(posedge SYS_CLK or posedge RST)
      begin
         if (RST)
         begin
            dp_out_ff[p] <= 1'b0;
            dm_out_ff[p] <= 1'b0;
            dp_oe_ff[p]  <= 1'b0;
            dm_oe_ff[p]  <= 1'b0;
            dp_in_ff[p]  <= 1'b0;
            dm_in_ff[p]  <= 1'b0;
         end
         else if (swap_ff[p] && HPM_SWAP_USED[p])
         begin
            dp_out_ff[p] <= CORE_DM_OUT[p];
            dm_out_ff[p] <= CORE_DP_OUT[p];
            dp_oe_ff[p]  <= CORE_DRV_EN[p];
            dm_oe_ff[p]  <= CORE_DRV_EN[p];
            dp_in_ff[p]  <= dm_sync_ff[p];
            dm_in_ff[p]  <= dp_sync_ff[p];
         end
         else
         begin
            dp_out_ff[p] <= CORE_DP_OUT[p];
            dm_out_ff[p] <= CORE_DM_OUT[p];
            dp_oe_ff[p]  <= CORE_DRV_EN[p];
            dm_oe_ff[p]  <= CORE_DRV_EN[p];
            dp_in_ff[p]  <= dp_sync_ff[p];
            dm_in_ff[p]  <= dm_sync_ff[p];
         end
      end
   end

   // effective logical code per physical port; identity while remap is off
   // the stored maps are kept while remap is off, so turning it back on
   // restores the last programmed numbering without a rewrite
   always_comb
   begin
      if (remap_enable)
      begin
         code[0] = map12_ff[3:0];
         code[1] = map12_ff[7:4];
         code[2] = map3_ff[3:0];
      end
      else
      begin
         code[0] = 4'h1;
         code[1] = 4'h2;
         code[2] = 4'h3;
      end
   end

   // per downstream port: a code counts only when it is non-zero and legal;
   // codes four to fifteen are forbidden to software, and treating them as
   // disabled keeps a stray write from aliasing two ports onto one number
   for (genvar d = 0; d < HPM_NUM_DS; d++)
   begin : g_code
      assign code_live[d] = (code[d] != HPM_CODE_OFF) && (code[d] <= HPM_CODE_MAX);
      assign code_num[d]  = code_live[d] ? code[d][1:0] : 2'h0;
   end

   // count enabled ports and find the physical port for the requested number;
   // illegal codes above three are treated as disabled, limiting the damage
   // duplicate numbers set several select bits; software must avoid them
   always_comb
   begin
      nxt_count = 2'h0;
      nxt_sel   = 3'h0;
      for (int i = 0; i < HPM_NUM_DS; i++)
      begin
         if (code_live[i])
         begin
            nxt_count = nxt_count + 2'h1;
            if (code_num[i] == REQ_LOGICAL)
            begin
               nxt_sel[i] = 1'b1;
            end
         end
      end
   end

   // registered routing and reported count; the host numbers 1..count
   // registering here costs one cycle after a request number changes, but
   // keeps the select free of glitches while the map is being decoded
   always_ff @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
      begin
         sel_ff     <= 3'h0;
         count_ff   <= 2'h0;
         logical_ff <= 6'h00;
      end
      else
      begin
         sel_ff     <= nxt_sel;
         count_ff   <= nxt_count;
         logical_ff <= {code_num[2], code_num[1], code_num[0]};
      end
   end

   // register port
   assign RDATA        = rdata_ff;

   // pin side: one cycle from core to pin, three from pin to core
   assign PIN_DP_OUT   = dp_out_ff;
   assign PIN_DM_OUT   = dm_out_ff;
   assign PIN_DP_OE    = dp_oe_ff;
   assign PIN_DM_OE    = dm_oe_ff;
   assign CORE_DP_IN   = dp_in_ff;
   assign CORE_DM_IN   = dm_in_ff;

   // remap results toward the hub core
   assign REQ_PHYS_SEL = sel_ff;
   assign PORT_COUNT   = count_ff;
   assign PORT_LOGICAL = logical_ff;

endmodule : hpm_port_remap

// [sim/hpm_monitor.sv]
// Purpose: port checker for pin role swap and logical port remap
// Assumes: register writes are shadowed here from the register port
// Notes:   drive and remap outputs are judged one cycle after their cause, pin senses three
module hpm_monitor
   import hpm_pkg::*;
(
   input wire logic       SYS_CLK,
   input wire logic       RST,
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic       WR,
   input wire logic       RD,
   input wire logic [7:0] RDATA,
   input wire logic [3:0] CORE_DP_OUT,
   input wire logic [3:0] CORE_DM_OUT,
   input wire logic [3:0] CORE_DRV_EN,
   input wire logic [3:0] PIN_DP_IN,
   input wire logic [3:0] PIN_DM_IN,
   input wire logic [3:0] PIN_DP_OUT,
   input wire logic [3:0] PIN_DM_OUT,
   input wire logic [3:0] PIN_DP_OE,
   input wire logic [3:0] PIN_DM_OE,
   input wire logic [3:0] CORE_DP_IN,
   input wire logic [3:0] CORE_DM_IN,
   input wire logic [1:0] REQ_LOGICAL,
   input wire logic [2:0] REQ_PHYS_SEL,
   input wire logic [1:0] PORT_COUNT,
   input wire logic [5:0] PORT_LOGICAL
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] sw_ff, m12_ff, m3_ff;
   logic       en_ff;
   logic [1:0] up_ff, cx;
   logic [3:0] s, edp, edm, eip, eim;
   logic [5:0] lg;
   logic [2:0] sx;
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   // illegal codes count as disabled, so a stray write cannot alias a port
   function automatic logic [1:0] cd(logic [3:0] c);
      return (c > HPM_CODE_MAX) ? 2'h0 : c[1:0];
   endfunction : cd
   // register shadow; up_ff counts edges since release, saturating at 3
   always_ff @(posedge SYS_CLK or posedge RST)
   begin
      if (RST)
         {sw_ff, m12_ff, m3_ff, en_ff, up_ff} <= {HPM_SWAP_RST, HPM_MAP12_RST, HPM_MAP3_RST, 3'h0};
      else
      begin
         if (up_ff != 2'h3) up_ff <= up_ff + 2'h1;
         if (WR && ADDR == HPM_ADDR_SWAP) sw_ff <= WDATA;
         if (WR && ADDR == HPM_ADDR_MAP12) m12_ff <= WDATA;
         if (WR && ADDR == HPM_ADDR_MAP3) m3_ff <= WDATA;
         if (WR && ADDR == HPM_ADDR_CTRL) en_ff <= WDATA[HPM_CTRL_EN_BIT];
      end
   end
   // expected values from the shadow
   assign s = sw_ff[3:0];
   assign edp = CORE_DP_OUT & ~s | CORE_DM_OUT & s;
   assign edm = CORE_DM_OUT & ~s | CORE_DP_OUT & s;
   assign eip = PIN_DP_IN & ~s | PIN_DM_IN & s;
   assign eim = PIN_DM_IN & ~s | PIN_DP_IN & s;
   assign lg = en_ff ? {cd(m3_ff[3:0]), cd(m12_ff[7:4]), cd(m12_ff[3:0])} : 6'h39;
   assign cx = {1'b0, lg[1:0] != 2'h0} + {1'b0, lg[3:2] != 2'h0} + {1'b0, lg[5:4] != 2'h0};
   assign sx = {3{REQ_LOGICAL != 2'h0}} & {lg[5:4] == REQ_LOGICAL, lg[3:2] == REQ_LOGICAL,
                                           lg[1:0] == REQ_LOGICAL};
   sequence rd_swap; RD && ADDR == HPM_ADDR_SWAP; endsequence
   sequence rd_map; RD && ADDR == HPM_ADDR_MAP12; endsequence
   swap_read_a: assert property (rd_swap |=> RDATA == $past(sw_ff))
      else $error("swap readback wrong");
   map_read_a: assert property (rd_map |=> RDATA == $past(m12_ff))
      else $error("map readback wrong");
   dp_drive_a: assert property (up_ff != 0 |-> PIN_DP_OUT == $past(edp))
      else $error("dp pin drive wrong");
   dm_drive_a: assert property (up_ff != 0 |-> PIN_DM_OUT == $past(edm))
      else $error("dm pin drive wrong");
   pin_enable_a: assert property (up_ff != 0 |-> PIN_DP_OE == $past(CORE_DRV_EN)
      && PIN_DM_OE == $past(CORE_DRV_EN)) else $error("pin enable wrong");
   dp_sense_a: assert property (up_ff == 2'h3 && $past(s, 3) == $past(s)
      |-> CORE_DP_IN == $past(eip, 3)) else $error("dp sense wrong");
   port_count_a: assert property (up_ff != 0 |-> PORT_COUNT == $past(cx))
      else $error("port count wrong");
   logical_map_a: assert property (up_ff != 0 |-> PORT_LOGICAL == $past(lg))
      else $error("logical numbers wrong");
   req_route_a: assert property (up_ff != 0 |-> REQ_PHYS_SEL == $past(sx))
      else $error("request routing wrong");
   dm_sense_a: assert property (up_ff == 2'h3 && $past(s, 3) == $past(s)
      |-> CORE_DM_IN == $past(eim, 3)) else $error("dm sense wrong");
   // the count behind a status read was registered one cycle before the strobe
   sequence rd_map3; RD && ADDR == HPM_ADDR_MAP3; endsequence
   sequence rd_stat; RD && ADDR == HPM_ADDR_STAT; endsequence
   map3_read_a: assert property (rd_map3 |=> RDATA == $past(m3_ff))
      else $error("port three map readback wrong");
   status_read_a: assert property (up_ff != 2'h0 ##0 rd_stat
      |=> RDATA == {6'h00, $past(cx, 2)}) else $error("status readback wrong");
   rdata_idle_a: assert property (!RD |=> RDATA == 8'h00)
      else $error("read data not cleared");
endmodule : hpm_monitor

bind hpm_port_remap hpm_monitor u_mon (.*);

// [sim/hpm_line_model.sv]
// Purpose: far-side line model for the four DP/DM pin pairs
// Assumes: far device drives a pin whenever the hub releases it
// Notes:   no bus keeper, so a released pin never shows the hub's last value
module hpm_line_model
(
   input  wire logic [3:0] dp_out,
   input  wire logic [3:0] dm_out,
   input  wire logic [3:0] dp_oe,
   input  wire logic [3:0] dm_oe,
   input  wire logic [3:0] far_dp,
   input  wire logic [3:0] far_dm,
   output logic      [3:0] dp_in,
   output logic      [3:0] dm_in
);
   timeunit 1ns;
   timeprecision 100ps;
   // hub drive wins per bit, else the far device's level
   assign dp_in = dp_oe & dp_out | ~dp_oe & far_dp;
   assign dm_in = dm_oe & dm_out | ~dm_oe & far_dm;
endmodule : hpm_line_model

// [sim/hpm_port_remap_tb.sv]
// Purpose: register-driven test of pin role swap and port remap
// Assumes: one clock, bench drives on rising edges
// Notes:   expectations built from the register codes written
`define CHK(n, e, v) begin checks_done++; if ((v) !== (e)) begin error_cnt++; \
   $display("MISMATCH %s exp %h seen %h", n, e, v); end end
module hpm_port_remap_tb
   import hpm_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 100ps;
   logic       sys_clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
   logic [3:0] dp_o = 4'h3, dm_o = 4'hc, drv = 4'hf, far_dp = 4'ha, far_dm = 4'h5;
   logic [3:0] pdp, pdm, pdpo, pdmo, dpoe, dmoe, cdpi, cdmi;
   logic [1:0] req = 2'h0, cnt;
   logic [2:0] sel, es;
   logic [5:0] lgc;
   int         error_cnt = 0, checks_done = 0;
   logic [7:0] ra[6] = '{HPM_ADDR_SWAP, HPM_ADDR_MAP12, HPM_ADDR_MAP3, HPM_ADDR_CTRL,
                         HPM_ADDR_STAT, 8'h10};
   logic [7:0] re[6] = '{HPM_SWAP_RST, HPM_MAP12_RST, HPM_MAP3_RST, HPM_CTRL_RST,
                         8'(HPM_NUM_DS), 8'h00};
   logic [7:0] sv[3] = '{8'hf5, 8'h0a, 8'h00};
   // map12, map3, ctrl, req, count, logical; only contiguous codes are written
   logic [31:0] rc[3] = '{32'h13021f27, 32'h01021a21, 32'h13020b39};
   always #5 sys_clk = ~sys_clk;
   hpm_port_remap DUT (.SYS_CLK(sys_clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
      .RD(rd), .RDATA(rdata), .CORE_DP_OUT(dp_o), .CORE_DM_OUT(dm_o), .CORE_DRV_EN(drv),
      .PIN_DP_IN(pdp), .PIN_DM_IN(pdm), .PIN_DP_OUT(pdpo), .PIN_DM_OUT(pdmo), .PIN_DP_OE(dpoe),
      .PIN_DM_OE(dmoe), .CORE_DP_IN(cdpi), .CORE_DM_IN(cdmi), .REQ_LOGICAL(req),
      .REQ_PHYS_SEL(sel), .PORT_COUNT(cnt), .PORT_LOGICAL(lgc));
   hpm_line_model u_line (.dp_out(pdpo), .dm_out(pdmo), .dp_oe(dpoe), .dm_oe(dmoe),
      .far_dp(far_dp), .far_dm(far_dm), .dp_in(pdp), .dm_in(pdm));
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : tick
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      {addr, wdata, wr} <= {a, d, 1'b1};
      @(posedge sys_clk);
      wr <= 1'b0;
   endtask : wr_reg
   // read data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string n);
      @(posedge sys_clk);
      {addr, rd} <= {a, 1'b1};
      @(posedge sys_clk);
      rd <= 1'b0;
      #1 `CHK(n, e, rdata)
   endtask : rd_chk
   task automatic finish_test();
      if (error_cnt == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : finish_test
   // cut a hang short after about 800 cycles
   initial
   begin
      #8000;
      error_cnt++;
      finish_test();
   end
   initial
   begin
      tick(4);
      rst <= 1'b0;
      foreach (ra[i]) rd_chk(ra[i], re[i], "reset read");
      // drive with pins driven, then sense with far side driving; reserved bits kept
      foreach (sv[i])
      begin
         wr_reg(HPM_ADDR_SWAP, sv[i]);
         drv <= 4'hf;
         tick(2);
         #1 `CHK("dp pin", dp_o & ~sv[i][3:0] | dm_o & sv[i][3:0], pdpo)
         `CHK("dm pin", dm_o & ~sv[i][3:0] | dp_o & sv[i][3:0], pdmo)
         `CHK("dp oe", 4'hf, dpoe)
         @(posedge sys_clk) drv <= 4'h0;
         tick(5);
         #1 `CHK("dp sense", far_dp & ~sv[i][3:0] | far_dm & sv[i][3:0], cdpi)
         `CHK("dm sense", far_dm & ~sv[i][3:0] | far_dp & sv[i][3:0], cdmi)
         `CHK("dm oe", 4'h0, dmoe)
         rd_chk(HPM_ADDR_SWAP, sv[i], "swap");
      end
      foreach (rc[i])
      begin
         wr_reg(HPM_ADDR_MAP12, rc[i][31:24]);
         wr_reg(HPM_ADDR_MAP3, rc[i][23:16]);
         wr_reg(HPM_ADDR_CTRL, {4'h0, rc[i][15:12]});
         req <= rc[i][11:10];
         tick(2);
         for (int p = 0; p < 3; p++) es[p] = rc[i][2*p +: 2] == rc[i][11:10];
         #1 `CHK("logical", rc[i][5:0], lgc)
         `CHK("count", rc[i][9:8], cnt)
         `CHK("route", es, sel)
         rd_chk(HPM_ADDR_MAP12, rc[i][31:24], "map12");
      end
      finish_test();
   end
endmodule : hpm_port_remap_tb
